/* pdal_top.sv */
// Purpose: excessive position deviation supervision with apb registers
// Assumes: positions are synchronous signed pulse counts
// Notes:   thresholds refresh continuously; alarm latches until cleared
`timescale 1ns/10ps
`default_nettype none
`include "pdal_params.svh"

// Overview of operation
// R01: Raise the deviation alarm when command minus feedback grows too big.
// R02: Rotary and direct drive levels are in rev, clamped at 200 rev.
// R03: Linear servo motor levels are in millimetres.
// R04: A zero level means 3 rev for rotary and 100 mm for linear motors.
// R05: Level and unit field reset to zero, so the substitute level applies.
// R06: Unit code 0,1,2,3 scales the level by 1, 0.1, 0.01, 0.001.
// R07: The same unit scales both the alarm and the warning level.
// R08: The unit field counts only in position control mode.
// R09: A pulse margin is largest at zero deviation and shrinks with it.
// R10: The alarm is raised the moment the margin reaches 0 pulse.
// R11: Fully closed loop takes its resolution from the load encoder.
// R12: A linear encoder resolution is numerator over denominator times 1000.
// R13: Software sets level times unit above margin span over resolution.
// R14: The level is turned into pulses; the alarm holds until cleared.
module pdal_top
  import pdal_pkg::*;
#(
  parameter int PW = 32,
  parameter int LW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [PW-1:0] cmdPos,
  input  wire logic [PW-1:0] fbPos,
  output logic               excessive_deviation_alarm,
  output logic               deviationWarning,
  output logic               irq
);
  // product width covers a 16-bit level times a 32-bit resolution
  localparam int NW = 48;
  localparam int DW = 26;

  // software settings
  logic [3:0]    ctrl, next_ctrl;
  logic [LW-1:0] param_alarm_level, next_alarm_level;
  logic [1:0]    param_level_unit, next_level_unit;
  logic [LW-1:0] param_warning_level, next_warning_level;
  logic [31:0]   motorRes, next_motorRes;
  logic [31:0]   loadRes, next_loadRes;
  logic [15:0]   linear_res_numerator, next_lin_num;
  logic [15:0]   linear_res_denominator, next_lin_den;
  logic [1:0]    intStat, next_intStat;
  logic [1:0]    intMask, next_intMask;
  logic          next_pready;
  logic [31:0]   next_prdata;
  logic          next_pslverr;
  logic          next_irq;

  // threshold and margin pipeline
  logic [PW-1:0] almThr, next_almThr;
  logic [PW-1:0] wrnThr, next_wrnThr;
  logic [1:0]    thrOk, next_thrOk;
  logic [PW-1:0] margin, next_margin;
  logic [PW:0]   absDev, next_absDev;
  logic          next_alarm;
  logic          next_warn;
  logic          mrgOk, next_mrgOk;

  logic          wrAcc;
  logic          clrAlm;
  logic [31:0]   resNum;
  logic [DW-1:0] resDen;
  logic [9:0]    unitDiv;
  logic [LW-1:0] lvlEff [2];
  logic [NW-1:0] dvd [2];
  logic [1:0]    dvBusy, dvDone;
  logic [PW-1:0] dvQuo [2];
  logic [PW:0]   rawDev;

  // decode shared by the threshold pair
  function automatic logic [LW-1:0] eff_level(input logic [LW-1:0] lv,
                                              input logic          lin);
    if (lv == '0 && lin) begin
      eff_level = LW'(`PDAL_DFLT_MM);                             // [R04]
    end else if (lv == '0) begin
      eff_level = LW'(`PDAL_DFLT_REV);                            // [R04]
    end else if (!lin && lv >= LW'(`PDAL_CLAMP_REV)) begin
      eff_level = LW'(`PDAL_CLAMP_REV);                           // [R02]
    end else begin
      // linear levels pass unclamped
      eff_level = lv;                                             // [R03]
    end
  endfunction

  always_comb begin
    case (param_level_unit)                                       // [R06]
      2'd0:    unitDiv = `PDAL_DIV_U0;
      2'd1:    unitDiv = `PDAL_DIV_U1;
      2'd2:    unitDiv = `PDAL_DIV_U2;
      default: unitDiv = `PDAL_DIV_U3;
    endcase
    // outside position mode the level is read in whole units
    if (!ctrl[`PDAL_CTRL_POSMODE]) begin
      unitDiv = `PDAL_DIV_U0;                                     // [R08]
    end
    // pulses per level step (rev or mm scaled by the unit) as a fraction resNum / resDen
    if (ctrl[`PDAL_CTRL_LINENC]) begin
      resNum = 32'(linear_res_numerator) * 32'(`PDAL_LIN_SCALE);  // [R12]
      resDen = DW'((linear_res_denominator == 16'h0000) ? 16'h0001
                   : linear_res_denominator) * DW'(unitDiv);
    end else begin
      resNum = ctrl[`PDAL_CTRL_FCLOSED] ? loadRes : motorRes;     // [R11]
      resDen = DW'(unitDiv);
    end
  end

  // same unit and resolution for alarm (0) and warning (1)
  // dividers restart as they finish; a new setting lands within two passes
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_thr
      always_comb begin
        lvlEff[gi] = eff_level(gi == 0 ? param_alarm_level
                                       : param_warning_level,
                               ctrl[`PDAL_CTRL_LINEAR]);
        dvd[gi] = NW'(lvlEff[gi]) * NW'(resNum);                  // [R14]
      end
      pdal_div #(.NW(NW), .DW(DW), .QW(PW)) u_div (               // [R07]
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (!dvBusy[gi]),
        .dividend (dvd[gi]),
        .divisor  (resDen),
        .busy     (dvBusy[gi]),
        .done     (dvDone[gi]),
        .quotient (dvQuo[gi])
      );
    end
  endgenerate

  always_comb begin
    next_almThr = dvDone[0] ? dvQuo[0] : almThr;
    next_wrnThr = dvDone[1] ? dvQuo[1] : wrnThr;
    // a threshold is known once its divider has finished a pass
    next_thrOk  = thrOk | dvDone;
    // one extra bit keeps the difference of two signed counts exact
    rawDev      = {cmdPos[PW-1], cmdPos} - {fbPos[PW-1], fbPos};
    next_absDev = rawDev[PW] ? (PW+1)'(-rawDev) : rawDev;         // [R01]
    // margin counts down from the threshold as deviation grows
    if ({1'b0, almThr} > absDev) begin
      next_margin = almThr - absDev[PW-1:0];                      // [R09]
    end else begin
      next_margin = '0;
    end
    // margin lags its threshold by a cycle; without the extra cycle the
    // zero margin left by reset would raise a false alarm
    next_mrgOk = thrOk[0];
    next_alarm = excessive_deviation_alarm;
    if (clrAlm) begin
      next_alarm = 1'b0;                                          // [R14]
    end
    if (mrgOk && margin == '0) begin
      next_alarm = 1'b1;                                          // [R10]
    end
    // the warning is a live level and is not held
    next_warn = thrOk[1] && (absDev >= {1'b0, wrnThr});
  end

  // every output of the block leaves from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      almThr                    <= '0;
      wrnThr                    <= '0;
      thrOk                     <= '0;
      mrgOk                     <= 1'b0;
      absDev                    <= '0;
      margin                    <= '0;
      excessive_deviation_alarm <= 1'b0;
      deviationWarning          <= 1'b0;
    end else begin
      almThr                    <= next_almThr;
      wrnThr                    <= next_wrnThr;
      thrOk                     <= next_thrOk;
      mrgOk                     <= next_mrgOk;
      absDev                    <= next_absDev;
      margin                    <= next_margin;
      excessive_deviation_alarm <= next_alarm;
      deviationWarning          <= next_warn;
    end
  end

  // apb: pready is a flop, so the slave answers one cycle into access
  assign wrAcc  = psel && penable && pready && pwrite;
  assign clrAlm = wrAcc && paddr == `PDAL_OFS_CMD
                  && pwdata[`PDAL_CMD_ALM_CLR];

  always_comb begin
    next_ctrl          = ctrl;
    next_alarm_level   = param_alarm_level;
    next_level_unit    = param_level_unit;
    next_warning_level = param_warning_level;
    next_motorRes      = motorRes;
    next_loadRes       = loadRes;
    next_lin_num       = linear_res_numerator;
    next_lin_den       = linear_res_denominator;
    next_intMask       = intMask;
    next_intStat       = intStat;
    next_pready        = psel && penable && !pready;
    next_prdata        = 32'h00000000;
    next_pslverr       = 1'b0;
    // read data are registered with pready and read zero otherwise
    if (psel && penable && !pready) begin
      case (paddr)
        `PDAL_OFS_CTRL:     next_prdata = 32'(ctrl);
        `PDAL_OFS_ALM_LVL:  next_prdata = 32'(param_alarm_level);
        `PDAL_OFS_UNIT:     next_prdata = 32'(param_level_unit);
        `PDAL_OFS_WRN_LVL:  next_prdata = 32'(param_warning_level);
        `PDAL_OFS_MOT_RES:  next_prdata = motorRes;
        `PDAL_OFS_LOAD_RES: next_prdata = loadRes;
        `PDAL_OFS_LIN_NUM:  next_prdata = 32'(linear_res_numerator);
        `PDAL_OFS_LIN_DEN:  next_prdata = 32'(linear_res_denominator);
        `PDAL_OFS_STATUS:   next_prdata = 32'({thrOk[0], deviationWarning,
                                          excessive_deviation_alarm});
        `PDAL_OFS_MARGIN:   next_prdata = 32'(margin);
        `PDAL_OFS_INT_STAT: next_prdata = 32'(intStat);
        `PDAL_OFS_INT_MASK: next_prdata = 32'(intMask);
        `PDAL_OFS_DEV:      next_prdata = absDev[PW-1:0];
        `PDAL_OFS_CMD:      next_prdata = 32'h00000000;
        // an unmapped offset answers with an error
        default:            next_pslverr = 1'b1;
      endcase
    end
    // read-only and unmapped offsets fall to the default and are dropped
    if (wrAcc) begin
      case (paddr)
        `PDAL_OFS_CTRL:     next_ctrl = pwdata[3:0];
        `PDAL_OFS_ALM_LVL:  next_alarm_level = pwdata[LW-1:0];
        `PDAL_OFS_UNIT:     next_level_unit = pwdata[1:0];
        `PDAL_OFS_WRN_LVL:  next_warning_level = pwdata[LW-1:0];
        `PDAL_OFS_MOT_RES:  next_motorRes = pwdata;
        `PDAL_OFS_LOAD_RES: next_loadRes = pwdata;
        `PDAL_OFS_LIN_NUM:  next_lin_num = pwdata[15:0];
        `PDAL_OFS_LIN_DEN:  next_lin_den = pwdata[15:0];
        `PDAL_OFS_INT_STAT: next_intStat = intStat & ~pwdata[1:0];
        `PDAL_OFS_INT_MASK: next_intMask = pwdata[1:0];
        default:            next_intMask = intMask;
      endcase
    end
    // events set after the clear, so a coincident event is kept
    if (next_alarm && !excessive_deviation_alarm) begin
      next_intStat[`PDAL_EV_ALARM] = 1'b1;
    end
    if (next_warn && !deviationWarning) begin
      next_intStat[`PDAL_EV_WARN] = 1'b1;
    end
    // built from next values so irq moves in step with intStat
    next_irq = |(next_intStat & next_intMask);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // zero level and unit select the substitute threshold out of reset
      ctrl                   <= `PDAL_RST_CTRL;
      param_alarm_level      <= `PDAL_RST_LEVEL;                  // [R05]
      param_level_unit       <= `PDAL_RST_UNIT;                   // [R05]
      param_warning_level    <= `PDAL_RST_LEVEL;
      motorRes               <= `PDAL_RST_RES;
      loadRes                <= `PDAL_RST_RES;
      linear_res_numerator   <= `PDAL_RST_LIN;
      linear_res_denominator <= `PDAL_RST_LIN;
      intStat                <= 2'h0;
      intMask                <= 2'h0;
      pready                 <= 1'b0;
      prdata                 <= 32'h00000000;
      pslverr                <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      ctrl                   <= next_ctrl;
      param_alarm_level      <= next_alarm_level;
      param_level_unit       <= next_level_unit;
      param_warning_level    <= next_warning_level;
      motorRes               <= next_motorRes;
      loadRes                <= next_loadRes;
      linear_res_numerator   <= next_lin_num;
      linear_res_denominator <= next_lin_den;
      intStat                <= next_intStat;
      intMask                <= next_intMask;
      pready                 <= next_pready;
      prdata                 <= next_prdata;
      pslverr                <= next_pslverr;
      irq                    <= next_irq;
    end
  end
endmodule
`default_nettype wire

/* pdal_params.svh */
// Purpose: constants of the position deviation alarm block
// Assumes: included by pdal_top, the checker and the bench
// Notes:   apb byte offsets, reset values and threshold figures
`ifndef PDAL_PARAMS_SVH
`define PDAL_PARAMS_SVH

`define PDAL_OFS_CTRL      8'h00
`define PDAL_OFS_ALM_LVL   8'h04
`define PDAL_OFS_UNIT      8'h08
`define PDAL_OFS_WRN_LVL   8'h0c
`define PDAL_OFS_MOT_RES   8'h10
`define PDAL_OFS_LOAD_RES  8'h14
`define PDAL_OFS_LIN_NUM   8'h18
`define PDAL_OFS_LIN_DEN   8'h1c
`define PDAL_OFS_STATUS    8'h20
`define PDAL_OFS_MARGIN    8'h24
`define PDAL_OFS_INT_STAT  8'h28
`define PDAL_OFS_INT_MASK  8'h2c
`define PDAL_OFS_DEV       8'h30
`define PDAL_OFS_CMD       8'h34

`define PDAL_CTRL_LINEAR   0
`define PDAL_CTRL_POSMODE  1
`define PDAL_CTRL_FCLOSED  2
`define PDAL_CTRL_LINENC   3
`define PDAL_CMD_ALM_CLR   0
`define PDAL_ST_ALARM      0
`define PDAL_ST_WARN       1
`define PDAL_ST_THR_OK     2
`define PDAL_EV_ALARM      0
`define PDAL_EV_WARN       1

`define PDAL_RST_CTRL      4'h2
`define PDAL_RST_LEVEL     16'h0000
`define PDAL_RST_UNIT      2'h0
`define PDAL_RST_RES       32'h00400000
`define PDAL_RST_LIN       16'h0001

`define PDAL_CLAMP_REV     16'd200
`define PDAL_DFLT_REV      16'd3
`define PDAL_DFLT_MM       16'd100
`define PDAL_LIN_SCALE     16'd1000
`define PDAL_DIV_U0        10'd1
`define PDAL_DIV_U1        10'd10
`define PDAL_DIV_U2        10'd100
`define PDAL_DIV_U3        10'd1000

`endif

/* pdal_pkg.sv */
// Purpose: shared types of the position deviation alarm block
// Assumes: constants live in pdal_params.svh
// Notes:   one-hot state codes written out
package pdal_pkg;
  typedef enum logic [2:0] {
    PDAL_DV_IDLE = 3'b001,
    PDAL_DV_RUN  = 3'b010,
    PDAL_DV_DONE = 3'b100
  } pdal_div_st_t;
endpackage

/* pdal_div.sv */
// Purpose: sequential restoring divider for threshold conversion
// Assumes: start is taken only while idle; divisor is never zero
// Notes:   one quotient bit per cycle; result saturates to QW bits
`timescale 1ns/10ps
`default_nettype none
module pdal_div
  import pdal_pkg::*;
#(
  parameter int NW = 48,
  parameter int DW = 26,
  parameter int QW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [NW-1:0] dividend,
  input  wire logic [DW-1:0] divisor,
  output logic               busy,
  output logic               done,
  output logic [QW-1:0]      quotient
);
  pdal_div_st_t    st, next_st;
  logic [NW-1:0]   quo, next_quo;
  logic [DW:0]     rem, next_rem;
  logic [DW-1:0]   dvs, next_dvs;
  logic [6:0]      cnt, next_cnt;
  logic [DW:0]     trial;

  always_comb begin
    next_st  = st;
    next_quo = quo;
    next_rem = rem;
    next_dvs = dvs;
    next_cnt = cnt;
    trial    = {rem[DW-1:0], quo[NW-1]};
    case (st)
      PDAL_DV_IDLE: begin
        if (start) begin
          next_quo = dividend;
          next_dvs = divisor;
          next_rem = '0;
          next_cnt = 7'(NW);
          next_st  = PDAL_DV_RUN;
        end
      end
      PDAL_DV_RUN: begin
        if (trial >= {1'b0, dvs}) begin
          next_rem = trial - {1'b0, dvs};
          next_quo = {quo[NW-2:0], 1'b1};
        end else begin
          next_rem = trial;
          next_quo = {quo[NW-2:0], 1'b0};
        end
        next_cnt = cnt - 7'd1;
        if (cnt == 7'd1) begin
          next_st = PDAL_DV_DONE;
        end
      end
      PDAL_DV_DONE: next_st = PDAL_DV_IDLE;
      default:      next_st = PDAL_DV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st  <= PDAL_DV_IDLE;
      quo <= '0;
      rem <= '0;
      dvs <= '0;
      cnt <= '0;
    end else begin
      st  <= next_st;
      quo <= next_quo;
      rem <= next_rem;
      dvs <= next_dvs;
      cnt <= next_cnt;
    end
  end

  assign busy     = (st != PDAL_DV_IDLE);
  assign done     = (st == PDAL_DV_DONE);
  // a threshold too large for the margin path saturates, never wraps
  assign quotient = (|quo[NW-1:QW]) ? {QW{1'b1}} : quo[QW-1:0];
endmodule
`default_nettype wire

/* pdal_checker.sv */
// Purpose: port-level checks of the position deviation alarm block
// Assumes: apb answers two cycles after setup; alarm lags input by three
// Notes:   bound to pdal_top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "pdal_params.svh"
module pdal_checker
  import pdal_pkg::*;
#(
  parameter int PW = 32
) (
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic [31:0]   prdata,
  input wire logic          pslverr,
  input wire logic [PW-1:0] cmdPos,
  input wire logic [PW-1:0] fbPos,
  input wire logic          excessive_deviation_alarm,
  input wire logic          deviationWarning,
  input wire logic          irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic clrHit;
  assign clrHit = psel && penable && pready && pwrite &&
                  paddr == `PDAL_OFS_CMD && pwdata[`PDAL_CMD_ALM_CLR];

  apb_answer_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside the answer");
  alarm_sticky_a: assert property (
    excessive_deviation_alarm && !clrHit && !$past(clrHit)
    |=> excessive_deviation_alarm) else $error("alarm dropped without clear");
  alarm_cause_a: assert property ($rose(excessive_deviation_alarm) |->
    $past(cmdPos, 2) != $past(fbPos, 2) || $past(cmdPos, 3) != $past(fbPos, 3)
    || $past(cmdPos, 4) != $past(fbPos, 4))
    else $error("alarm rose without deviation");
  quiet_zero_a: assert property (!excessive_deviation_alarm &&
    cmdPos == fbPos && $past(cmdPos) == $past(fbPos) &&
    $past(cmdPos, 2) == $past(fbPos, 2) && $past(cmdPos, 3) == $past(fbPos, 3)
    |=> !excessive_deviation_alarm) else $error("alarm at zero deviation");
  irq_cause_a: assert property ($rose(irq) |-> $past(psel) ||
    excessive_deviation_alarm || deviationWarning)
    else $error("irq rose without event or mask write");
endmodule
bind pdal_top pdal_checker #(.PW(PW)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cmdPos(cmdPos), .fbPos(fbPos),
  .excessive_deviation_alarm(excessive_deviation_alarm),
  .deviationWarning(deviationWarning), .irq(irq)
);
`default_nettype wire

/* pdal_pos_model.sv */
// Purpose: command generator and encoder feedback for the alarm block
// Assumes: devSet is the wanted command minus feedback in pulses
// Notes:   positions keep moving so the alarm sees a live axis
`timescale 1ns/10ps
`default_nettype none
module pdal_pos_model #(
  parameter int PW = 32
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic [PW-1:0] devSet,
  output logic      [PW-1:0] cmdPos,
  output logic      [PW-1:0] fbPos
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdPos <= '0;
      fbPos <= '0;
    end else begin
      cmdPos <= cmdPos + PW'(3);
      fbPos <= cmdPos + PW'(3) - devSet;
    end
  end
endmodule
`default_nettype wire

/* pdal_top_tb.sv */
// Purpose: self-checking bench of the position deviation alarm block
// Assumes: apb master below; positions from pdal_pos_model
// Notes:   threshold table rows, then warning, irq, error and reset cases
`timescale 1ns/10ps
`default_nettype none
`include "pdal_params.svh"
module pdal_top_tb;
  import pdal_pkg::*;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [15:0] lvl;
    logic [1:0]  unit;
    logic [31:0] thr;
  } pdal_row_t;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, errv;
  logic        alarm, warn, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, devSet, rdv, cmdPos, fbPos;
  int          mismatches, samples_checked;
  pdal_row_t   rows[10];

  pdal_top dut_u (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .cmdPos(cmdPos),
    .fbPos(fbPos), .excessive_deviation_alarm(alarm),
    .deviationWarning(warn), .irq(irq));
  pdal_pos_model pos_u (.sys_clk(sys_clk), .rst(rst), .devSet(devSet),
    .cmdPos(cmdPos), .fbPos(fbPos));

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      summarize();
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; devSet = 32'h0;
    // motor res 1000, load res 2000, linear encoder 3/2
    rows = '{'{4'h2, 16'h0, 2'h0, 32'hbb8}, '{4'h2, 16'hfa, 2'h0, 32'h30d40},
      '{4'h2, 16'h5, 2'h1, 32'h1f4}, '{4'h2, 16'h7, 2'h2, 32'h46},
      '{4'h2, 16'h9, 2'h3, 32'h9}, '{4'h3, 16'h0, 2'h0, 32'h186a0},
      '{4'h3, 16'hfa, 2'h0, 32'h3d090}, '{4'h0, 16'h5, 2'h3, 32'h1388},
      '{4'h6, 16'h2, 2'h0, 32'hfa0}, '{4'ha, 16'h2, 2'h0, 32'hbb8}};
    cyc(10);
    rst <= 1'b0;
    apb(1'b0, `PDAL_OFS_CTRL, 32'h0);
    chk(rdv, 32'h2);
    apb(1'b0, `PDAL_OFS_ALM_LVL, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, `PDAL_OFS_UNIT, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b1, `PDAL_OFS_MOT_RES, 32'h3e8);
    apb(1'b1, `PDAL_OFS_LOAD_RES, 32'h7d0);
    apb(1'b1, `PDAL_OFS_LIN_NUM, 32'h3);
    apb(1'b1, `PDAL_OFS_LIN_DEN, 32'h2);
    foreach (rows[i]) begin
      apb(1'b1, `PDAL_OFS_CTRL, {28'h0, rows[i].ctrl});
      apb(1'b1, `PDAL_OFS_ALM_LVL, {16'h0, rows[i].lvl});
      apb(1'b1, `PDAL_OFS_UNIT, {30'h0, rows[i].unit});
      cyc(200);
      apb(1'b0, `PDAL_OFS_MARGIN, 32'h0);
      chk(rdv, rows[i].thr);
      devSet <= rows[i].thr - 32'h1;
      cyc(8);
      chk({31'h0, alarm}, 32'h0);
      apb(1'b0, `PDAL_OFS_MARGIN, 32'h0);
      chk(rdv, 32'h1);
      devSet <= rows[i].thr;
      cyc(8);
      chk({31'h0, alarm}, 32'h1);
      devSet <= 32'h0;
      cyc(8);
      chk({31'h0, alarm}, 32'h1);
      apb(1'b1, `PDAL_OFS_CMD, 32'h1);
      cyc(4);
      chk({31'h0, alarm}, 32'h0);
      $display("row %0d done", i);
    end
    apb(1'b1, `PDAL_OFS_CTRL, 32'h2);
    apb(1'b1, `PDAL_OFS_ALM_LVL, 32'h64);
    apb(1'b1, `PDAL_OFS_UNIT, 32'h1);
    apb(1'b1, `PDAL_OFS_WRN_LVL, 32'h4);
    cyc(200);
    devSet <= 32'h18f;
    cyc(8);
    chk({31'h0, warn}, 32'h0);
    devSet <= 32'h190;
    cyc(8);
    chk({31'h0, warn}, 32'h1);
    apb(1'b0, `PDAL_OFS_DEV, 32'h0);
    chk(rdv, 32'h190);
    apb(1'b0, `PDAL_OFS_STATUS, 32'h0);
    chk(rdv, 32'h6);
    $display("warning unit done");
    apb(1'b1, `PDAL_OFS_INT_STAT, 32'h3);
    apb(1'b1, `PDAL_OFS_INT_MASK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    // a deviation of 10000 pulses in the negative direction
    devSet <= 32'hffffd8f0;
    cyc(8);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `PDAL_OFS_DEV, 32'h0);
    chk(rdv, 32'h2710);
    devSet <= 32'h0;
    apb(1'b1, `PDAL_OFS_CMD, 32'h1);
    cyc(4);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `PDAL_OFS_INT_STAT, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `PDAL_OFS_INT_STAT, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    $display("irq and unmapped done");
    devSet <= 32'h2710;
    cyc(8);
    rst <= 1'b1;
    cyc(10);
    chk({31'h0, alarm}, 32'h0);
    rst <= 1'b0;
    apb(1'b0, `PDAL_OFS_UNIT, 32'h0);
    chk(rdv, 32'h0);
    cyc(60);
    chk({31'h0, alarm}, 32'h0);
    apb(1'b0, `PDAL_OFS_MARGIN, 32'h0);
    chk(rdv, 32'h00bfd8f0);
    $display("mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
